// ### core/boot_and_low_power_control.sv
// Notes on behaviour
// - Mode picked from pins at reset rise
// - Loader only when security_lock reads one
// - Loader bytes stored from base upward
// - First byte is count incl itself
// - Jump to byte after count when done
// - 8N1 link at 9600 baud
// - Short data: keep waiting, RAM kept
// - STOP halts; irq or reset wakes
// - STOP clears interrupt mask
// - STOP clears slow_select
// - Wake fetches matching vector pair
// - Hold CPU wake_delay cycles after wake
// - Resume by interrupt or reset vector
// - STOP freezes peripherals, resets watchdog
// - WAIT halts CPU, peripherals keep running
// - WAIT clears mask, keeps ext_irq_enable
// - WAIT exits on irq/timer/serial/reset
// - Reset exit resets, others preserved
// - slow_select adds divide by sixteen
// - slow_select bit one, cleared by reset
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Small FIFO between the serial receiver and RAM writer
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	// Elaboration check: pointer wrap logic needs a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin : g_bad_depth
		$error("DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d; // Pointers with wrap bit
	logic full, empty, push, pop;
	// Flags and next pointers
	always_comb
	begin
		full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
		empty = (wr_q == rd_q);
		push = i_in_valid && !full;
		pop = i_out_ready && !empty;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		mem_d = mem_q;
		if (push)
			mem_d[wr_q[AW-1:0]] = i_in_data;
	end
	// Registers
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else if (i_ce)
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			mem_q <= mem_d;
		end
	end
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem_q[rd_q[AW-1:0]];
endmodule : byte_fifo

////////////////////////////////////////////////////////////////////////////////
// Boot mode selection, serial loader, STOP/WAIT/SLOW control
module boot_and_low_power_control #(
	parameter int WAKE_CYC = boot_lp_pkg::WAKE_LONG, // Mask option
	parameter int BIT_CYCLES = boot_lp_pkg::BIT_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn, // Reset pin or power-on
	input wire logic i_ce,
	input wire logic i_irq_overvolt, // Interrupt pin at twice supply
	input wire logic i_capture_one_pin,
	input wire logic i_boot_select_a,
	input wire logic i_boot_select_b,
	input wire logic i_security_lock,
	input wire logic [7:0] i_port_a,
	input wire logic [7:0] i_port_b,
	input wire logic [7:0] i_port_c,
	input wire logic i_rx, // Serial line, idle high
	input wire logic i_stop_req, // Pulse: STOP executed
	input wire logic i_wait_req, // Pulse: WAIT executed
	input wire logic i_ext_irq, // Wake events
	input wire logic i_timer_irq,
	input wire logic i_serial_irq,
	input wire logic i_slow_wr, // Write of slow_select
	input wire logic i_slow_wdata,
	input wire logic i_ext_irq_enable,
	output logic [1:0] o_boot_mode,
	output logic o_ram_we,
	output logic [15:0] o_ram_addr,
	output logic [7:0] o_ram_wdata,
	output logic o_jump, // Pulse: PC load
	output logic [15:0] o_jump_addr,
	output logic o_cpu_run,
	output logic o_osc_on,
	output logic o_periph_run, // Timer, serial, converter
	output logic o_eeprom_ro,
	output logic o_wdog_clear,
	output logic o_clear_imask,
	output logic o_slow_select,
	output logic o_ext_irq_enable,
	output logic o_bus_tick // Bus clock enable
);
	import boot_lp_pkg::*;
	// Elaboration checks: two wake options only; a bit time must fit the baud counter
	if (WAKE_CYC != WAKE_SHORT && WAKE_CYC != WAKE_LONG)
	begin : g_bad_wake
		$error("WAKE_CYC must be one of the two options");
	end
	if (BIT_CYCLES < 4 || BIT_CYCLES > 65535)
	begin : g_bad_bit
		$error("BIT_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Three-stage synchronisers on pins; change counts once stages 2,3 agree
	localparam int NS = 5;
	logic [NS-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q, pin_d;
	assign pin_raw = {i_rx, i_irq_overvolt, i_capture_one_pin, i_boot_select_a,
		i_boot_select_b};
	always_comb
	begin
		for (int k = 0; k < NS; k++)
			pin_d[k] = (s2_q[k] == s3_q[k]) ? s3_q[k] : pin_q[k];
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
			pin_q <= 5'h10;
		else if (i_ce)
			pin_q <= pin_d;
		if (i_ce)
		begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	logic rx_s, ovv_s, cap_s, sel_a_s, sel_b_s;
	assign {rx_s, ovv_s, cap_s, sel_a_s, sel_b_s} = pin_q;

	////////////////////////////////////////////////////////////////////////////
	// Mode latch, loader receiver and power state
	typedef enum logic [2:0] {ST_SAMPLE, ST_RUN, ST_LOAD, ST_STOP, ST_WAKE, ST_WAIT} state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	state_t st_q, st_d;
	rx_state_t rx_q, rx_d;
	logic [1:0] mode_q, mode_d;
	logic [3:0] samp_q, samp_d; // Waits for synchronisers after release
	logic [15:0] bcnt_q, bcnt_d; // Baud counter
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic rx_v;
	logic [7:0] cnt_q, cnt_d; // Byte count from host
	logic [7:0] got_q, got_d; // Bytes stored so far
	logic [12:0] wake_q, wake_d;
	logic wake_irq_q, wake_irq_d;
	logic slow_q, slow_d, ien_q, ien_d, imask_q, imask_d;
	logic jump_q, jump_d, we_q, we_d;
	logic [15:0] jaddr_q, jaddr_d, addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d;
	logic [4:0] div_q, div_d;
	logic tick_q, tick_d;
	logic fi_ready, fo_valid;
	logic [7:0] fo_data;

	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_in_valid(rx_v),
		.o_in_ready(fi_ready),
		.i_in_data(sh_q),
		.o_out_valid(fo_valid),
		.i_out_ready(st_q == ST_LOAD),
		.o_out_data(fo_data)
	);

	// Serial receiver, 8N1, bit time as a count of system cycles
	always_comb
	begin
		rx_d = rx_q;
		bcnt_d = bcnt_q;
		bit_d = bit_q;
		sh_d = sh_q;
		rx_v = 1'b0;
		case (rx_q)
			RX_IDLE:
				if (!rx_s && st_q == ST_LOAD)
				begin
					rx_d = RX_START;
					bcnt_d = 16'(BIT_CYCLES / 2);
				end
			RX_START:
				if (bcnt_q == 16'h0)
				begin
					rx_d = rx_s ? RX_IDLE : RX_DATA; // False start rejected
					bcnt_d = 16'(BIT_CYCLES - 1);
					bit_d = 3'h0;
				end
				else
					bcnt_d = bcnt_q - 16'h1;
			RX_DATA:
				if (bcnt_q == 16'h0)
				begin
					sh_d = {rx_s, sh_q[7:1]}; // LSB first
					bcnt_d = 16'(BIT_CYCLES - 1);
					bit_d = bit_q + 3'h1;
					if (bit_q == 3'h7)
						rx_d = RX_STOP;
				end
				else
					bcnt_d = bcnt_q - 16'h1;
			RX_STOP:
				if (bcnt_q == 16'h0)
				begin
					// Framing error drops the byte; a full FIFO also drops it
					rx_v = rx_s && fi_ready;
					rx_d = RX_IDLE;
				end
				else
					bcnt_d = bcnt_q - 16'h1;
			default:
				rx_d = RX_IDLE;
		endcase
	end

	// Main sequencer
	always_comb
	begin
		st_d = st_q;
		mode_d = mode_q;
		samp_d = samp_q;
		cnt_d = cnt_q;
		got_d = got_q;
		wake_d = wake_q;
		wake_irq_d = wake_irq_q;
		slow_d = slow_q;
		ien_d = i_ext_irq_enable;
		imask_d = 1'b0;
		jump_d = 1'b0;
		we_d = 1'b0;
		jaddr_d = jaddr_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		if (i_slow_wr)
			slow_d = i_slow_wdata;
		case (st_q)
			ST_SAMPLE:
				// Synchronisers settle within a few cycles; host holds 30 bus cycles
				if (samp_q == 4'h7)
				begin
					st_d = ST_RUN;
					mode_d = MODE_SINGLE;
					if (ovv_s && cap_s && sel_a_s)
					begin
						if (sel_b_s)
						begin
							mode_d = MODE_JUMP;
							if (i_port_a == JUMP_KEY)
							begin
								jump_d = 1'b1;
								jaddr_d = {i_port_b, i_port_c};
							end
						end
						else if (i_security_lock)
						begin
							mode_d = MODE_LOADER;
							st_d = ST_LOAD;
							got_d = 8'h0;
						end
						else
							mode_d = MODE_LOCKED;
					end
				end
				else
					samp_d = samp_q + 4'h1;
			ST_LOAD:
				// Short data leaves us here until reset; RAM is not touched by reset
				if (fo_valid)
				begin
					we_d = 1'b1;
					addr_d = LOAD_BASE + 16'(got_q);
					wdata_d = fo_data;
					if (got_q == 8'h0)
						cnt_d = fo_data;
					got_d = got_q + 8'h1;
					if (got_q != 8'h0 && got_q + 8'h1 == cnt_q)
					begin
						jump_d = 1'b1;
						jaddr_d = PROG_START;
						st_d = ST_RUN;
					end
				end
			ST_RUN:
				if (i_stop_req)
				begin
					st_d = ST_STOP;
					slow_d = 1'b0;
				end
				else if (i_wait_req)
					st_d = ST_WAIT;
			ST_STOP:
			begin
				slow_d = 1'b0;
				if (i_ext_irq)
				begin
					st_d = ST_WAKE;
					wake_d = 13'(WAKE_CYC - 1);
					wake_irq_d = 1'b1;
				end
			end
			ST_WAKE:
				if (wake_q == 13'h0)
				begin
					st_d = ST_RUN;
					jump_d = 1'b1;
					jaddr_d = wake_irq_q ? VEC_EXT_IRQ : VEC_RESET;
				end
				else if (o_bus_tick)
					wake_d = wake_q - 13'h1;
			ST_WAIT:
			begin
				if (i_ext_irq || i_timer_irq || i_serial_irq)
					st_d = ST_RUN;
			end
			default:
				st_d = ST_SAMPLE;
		endcase
		// Mask clear follows the next state, so it shows on the first cycle of STOP or WAIT
		imask_d = (st_d == ST_STOP) || (st_d == ST_WAIT);
	end

	// Clock divider: osc/2 normally, extra divide by 16 when slow
	always_comb
	begin
		div_d = div_q + 5'h1;
		tick_d = 1'b0;
		if (div_q >= 5'(slow_q ? DIV_SLOW - 1 : DIV_NORMAL - 1))
		begin
			div_d = 5'h0;
			tick_d = (st_q != ST_STOP); // Oscillator off in STOP
		end
	end

	// Registers; a low reset pin also wakes STOP and WAIT as a full reset
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			st_q <= ST_SAMPLE;
			rx_q <= RX_IDLE;
			mode_q <= MODE_SINGLE;
			samp_q <= 4'h0;
			cnt_q <= 8'h0;
			got_q <= 8'h0;
			wake_q <= 13'h0;
			wake_irq_q <= 1'b0;
			slow_q <= 1'b0;
			ien_q <= 1'b0;
			imask_q <= 1'b0;
			jump_q <= 1'b0;
			we_q <= 1'b0;
			jaddr_q <= VEC_RESET;
			addr_q <= LOAD_BASE;
			wdata_q <= 8'h0;
			div_q <= 5'h0;
			tick_q <= 1'b0;
			bcnt_q <= 16'h0;
			bit_q <= 3'h0;
			sh_q <= 8'h0;
		end
		else if (i_ce)
		begin
			st_q <= st_d;
			rx_q <= rx_d;
			mode_q <= mode_d;
			samp_q <= samp_d;
			cnt_q <= cnt_d;
			got_q <= got_d;
			wake_q <= wake_d;
			wake_irq_q <= wake_irq_d;
			slow_q <= slow_d;
			ien_q <= ien_d;
			imask_q <= imask_d;
			jump_q <= jump_d;
			we_q <= we_d;
			jaddr_q <= jaddr_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			div_q <= div_d;
			tick_q <= tick_d;
			bcnt_q <= bcnt_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops
	logic run_q, osc_q, per_q, ro_q, wd_q;
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			run_q <= 1'b0;
			osc_q <= 1'b1;
			per_q <= 1'b1;
			ro_q <= 1'b0;
			wd_q <= 1'b1;
		end
		else if (i_ce)
		begin
			run_q <= (st_d == ST_RUN);
			osc_q <= (st_d != ST_STOP);
			per_q <= (st_d != ST_STOP) && (st_d != ST_WAKE);
			ro_q <= (st_d == ST_STOP);
			wd_q <= (st_d == ST_STOP);
		end
	end
	assign o_boot_mode = mode_q;
	assign o_ram_we = we_q;
	assign o_ram_addr = addr_q;
	assign o_ram_wdata = wdata_q;
	assign o_jump = jump_q;
	assign o_jump_addr = jaddr_q;
	assign o_cpu_run = run_q;
	assign o_osc_on = osc_q;
	assign o_periph_run = per_q;
	assign o_eeprom_ro = ro_q;
	assign o_wdog_clear = wd_q;
	assign o_clear_imask = imask_q;
	assign o_slow_select = slow_q;
	assign o_ext_irq_enable = ien_q;
	assign o_bus_tick = tick_q;
endmodule : boot_and_low_power_control
`default_nettype wire

// ### core/boot_lp_pkg.sv
package boot_lp_pkg;
	// Boot modes chosen at reset release
	typedef enum logic [1:0] {MODE_SINGLE, MODE_LOADER, MODE_JUMP, MODE_LOCKED} boot_mode_t;
	// Loader addressing
	localparam logic [15:0] LOAD_BASE = 16'h0050;
	localparam logic [15:0] PROG_START = 16'h0051;
	localparam logic [7:0] JUMP_KEY = 8'hcc;
	// Wake vectors
	localparam logic [15:0] VEC_EXT_IRQ = 16'h1ffa;
	localparam logic [15:0] VEC_RESET = 16'h1ffe;
	// Wake delay options, internal cycles
	localparam int WAKE_SHORT = 16;
	localparam int WAKE_LONG = 4064;
	// Clock division
	localparam int DIV_NORMAL = 2;
	localparam int DIV_SLOW = 32;
	// Miscellaneous register slow bit position
	localparam int SLOW_BIT = 1;
	// Serial link: 9600 baud at 4 MHz oscillator, system clock 125 MHz
	localparam int BAUD = 9600;
	localparam int SYS_HZ = 125000000;
	localparam int BIT_CYC = SYS_HZ / BAUD;
	localparam int FIFO_DEPTH = 8;
endpackage : boot_lp_pkg

// ### testbench/boot_and_low_power_control_sva.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Ordering checks on the low-power ports
module boot_lp_sva
	import boot_lp_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_stop_req,
	input wire logic i_wait_req,
	input wire logic i_ext_irq,
	input wire logic i_timer_irq,
	input wire logic i_serial_irq,
	input wire logic i_slow_wr,
	input wire logic i_slow_wdata,
	input wire logic o_jump,
	input wire logic [15:0] o_jump_addr,
	input wire logic o_cpu_run,
	input wire logic o_osc_on,
	input wire logic o_periph_run,
	input wire logic o_eeprom_ro,
	input wire logic o_wdog_clear,
	input wire logic o_clear_imask,
	input wire logic o_slow_select
);
	logic stop_q; // In STOP until the wake jump
	logic wait_q; // In WAIT until the CPU runs
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	// Trackers; reset drops both since reset leaves either mode
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			stop_q <= 1'b0;
			wait_q <= 1'b0;
		end
		else
		begin
			stop_q <= i_stop_req | (stop_q & !o_jump);
			wait_q <= i_wait_req | (wait_q & !o_cpu_run);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_stop_osc_off: assert property (i_stop_req |=> !o_osc_on && !o_slow_select)
		else $error("STOP left oscillator or slow mode on");
	a_stop_mask: assert property (i_stop_req |=> o_clear_imask)
		else $error("STOP kept interrupt mask");
	a_stop_freeze: assert property (i_stop_req |-> ##[1:2] (o_wdog_clear && o_eeprom_ro && !o_periph_run))
		else $error("STOP did not freeze peripherals");
	a_wake_vector: assert property (stop_q && o_jump |-> o_jump_addr == VEC_EXT_IRQ)
		else $error("STOP wake used wrong vector");
	a_wake_hold: assert property (stop_q && !o_jump |-> !o_cpu_run)
		else $error("CPU ran during STOP or wake delay");
	a_wait_cpu: assert property (i_wait_req |=> !o_cpu_run && o_periph_run && o_clear_imask)
		else $error("WAIT entry wrong");
	a_wait_exit: assert property (wait_q && (i_ext_irq || i_timer_irq || i_serial_irq) |=> o_cpu_run)
		else $error("WAIT not left on interrupt");
	a_slow_bit: assert property (i_slow_wr && i_ce && !i_stop_req |=> o_slow_select == $past(i_slow_wdata))
		else $error("slow_select write lost");
	c_loader_jump: cover property (o_jump && o_jump_addr == PROG_START);
	c_stop_wake: cover property (stop_q && o_jump);
	c_wait_exit: cover property (wait_q && o_cpu_run);
endmodule : boot_lp_sva
bind boot_and_low_power_control boot_lp_sva sva (.*);
`default_nettype wire

// ### testbench/boot_and_low_power_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module boot_and_low_power_control_tb;
	import boot_lp_pkg::*;
	localparam int WK = 16; // Short wake option keeps runs brief
	localparam int BC = 16; // Clocks a serial bit
	logic clk, rstn, ov, cap, sa, sb, lk, rx, stp, wt, go, busy, swr, swd, ien, ce;
	logic [2:0] irq; // Serial, timer, external
	logic [7:0] pa, pb, pc, txb, wd;
	logic [1:0] mode;
	logic we, jmp, run, osc, per, ro, wdc, cim, slow, ieo, tick;
	logic [15:0] addr, jad, jaddr;
	logic [23:0] wq[$]; // Captured RAM writes
	logic [7:0] q[$];
	int miscompares, n_compared, jcnt, cyc, i, k, wn, j0;
	boot_and_low_power_control #(.WAKE_CYC(WK), .BIT_CYCLES(BC)) dut (.i_sys_clk(clk),
		.i_rstn(rstn), .i_ce(ce), .i_irq_overvolt(ov), .i_capture_one_pin(cap),
		.i_boot_select_a(sa), .i_boot_select_b(sb), .i_security_lock(lk), .i_port_a(pa),
		.i_port_b(pb), .i_port_c(pc), .i_rx(rx), .i_stop_req(stp), .i_wait_req(wt),
		.i_ext_irq(irq[0]), .i_timer_irq(irq[1]), .i_serial_irq(irq[2]), .i_slow_wr(swr),
		.i_slow_wdata(swd), .i_ext_irq_enable(ien), .o_boot_mode(mode), .o_ram_we(we),
		.o_ram_addr(addr), .o_ram_wdata(wd), .o_jump(jmp), .o_jump_addr(jad), .o_cpu_run(run),
		.o_osc_on(osc), .o_periph_run(per), .o_eeprom_ro(ro), .o_wdog_clear(wdc),
		.o_clear_imask(cim), .o_slow_select(slow), .o_ext_irq_enable(ieo), .o_bus_tick(tick));
	host_uart_model #(.BITC(BC)) host (.i_clk(clk), .i_go(go), .i_byte(txb), .o_busy(busy),
		.o_rx(rx));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Monitor of writes and jumps, plus the hang limit
	always @(posedge clk)
	begin
		if (we === 1'b1) wq.push_back({addr, wd});
		if (jmp === 1'b1) jaddr = jad;
		if (jmp === 1'b1) jcnt++;
		cyc++;
		if (cyc == 30000)
		begin
			miscompares++;
			close_out();
		end
	end
	function automatic logic [1:0] exp_mode(input logic o, c, a, b, l);
		if (!(o && c && a)) return MODE_SINGLE;
		if (b) return MODE_JUMP;
		return l ? MODE_LOADER : MODE_LOCKED;
	endfunction : exp_mode
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Pins held well past the thirty machine cycles after release
	task automatic boot(input logic o, c, a, b, l);
		{ov, cap, sa, sb, lk} = {o, c, a, b, l};
		ien = 1'($urandom);
		rstn = 1'b0;
		repeat (16) step;
		rstn = 1'b1;
		repeat (80) step;
		chk("mode", 16'(exp_mode(o, c, a, b, l)), 16'(mode));
	endtask : boot
	task automatic send(input logic [7:0] b);
		txb = b;
		go = 1'b1;
		step;
		go = 1'b0;
		for (k = 0; k < 400 && busy; k++) step;
	endtask : send
	task automatic load(input int n, input int m);
		q = {8'(n)};
		wq.delete();
		for (i = 1; i < m; i++) q.push_back(8'($urandom));
		for (i = 0; i < m; i++) send(q[i]);
		repeat (20) step;
		chk("writes", 16'(m), 16'(wq.size()));
		for (i = 0; i < m; i++) chk("waddr", LOAD_BASE + 16'(i), wq[i][23:8]);
		for (i = 0; i < m; i++) chk("wdata", 16'(q[i]), 16'(wq[i][7:0]));
	endtask : load
	task automatic pulse(input int w);
		{wt, stp} = 2'(w);
		step;
		{wt, stp} = 2'b00;
	endtask : pulse
	task automatic ticks(input int e);
		int c;
		c = 0;
		repeat (40) step;
		for (k = 0; k < 64; k++)
		begin
			step;
			if (tick === 1'b1) c++;
		end
		chk("ticks", 16'(e), 16'(c));
	endtask : ticks
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		{rstn, ov, cap, sa, sb, lk, stp, wt, go, swr, swd, ien, irq} = '0;
		{pa, pb, pc, txb} = '0;
		ce = 1'b1;
		void'($urandom(51));
		boot(1, 1, 1, 0, 0);
		$display("test done: locked");
		boot(1, 1, 1, 0, 1);
		load(4, 4);
		chk("jump", PROG_START, jaddr);
		$display("test done: loader");
		j0 = jcnt;
		boot(1, 1, 1, 0, 1);
		load(6, 4);
		repeat (300) step;
		chk("held", 16'(j0), 16'(jcnt));
		$display("test done: held");
		{pa, pb, pc} = {JUMP_KEY, 8'($urandom), 8'($urandom)};
		boot(1, 1, 1, 1, 1);
		chk("jaddr", {pb, pc}, jaddr);
		// Wrong key: the jump must not happen
		j0 = jcnt;
		pa = JUMP_KEY ^ 8'(1 + $urandom % 255);
		boot(1, 1, 1, 1, 1);
		chk("nokey", 16'(j0), 16'(jcnt));
		$display("test done: jump");
		boot(0, 0, 0, 0, 1);
		// A write while the clock enable is low must not land
		ce = 1'b0;
		{swr, swd} = 2'b11;
		step;
		chk("frozen", 16'h0, 16'(slow));
		ce = 1'b1;
		step;
		swr = 1'b0;
		chk("slow", 16'h1, 16'(slow));
		ticks(2);
		pulse(1);
		chk("osc", 16'h0, 16'(osc));
		chk("slow_stop", 16'h0, 16'(slow));
		chk("smask", 16'h1, 16'(cim));
		chk("sfrz", 16'h1, 16'({wdc, ro, per} == 3'b110));
		i = jcnt;
		irq = 3'b001;
		for (wn = 0; wn < 300 && jcnt == i; wn++) step;
		irq = 3'b000;
		chk("wvec", VEC_EXT_IRQ, jaddr);
		chk("wdelay", 16'h1, 16'(wn >= 2 * WK && wn < 2 * WK + 24));
		ticks(32);
		$display("test done: stop");
		for (i = 0; i < 3; i++)
		begin
			pulse(2);
			chk("wrun", 16'h0, 16'(run));
			chk("wien", 16'(ien), 16'(ieo));
			chk("wmask", 16'h1, 16'(cim));
			chk("wper", 16'h1, 16'(per));
			irq = 3'(1 << i);
			step;
			irq = 3'b000;
			chk("wexit", 16'h1, 16'(run));
			repeat (10) step;
		end
		{swr, swd} = 2'b11;
		step;
		swr = 1'b0;
		pulse(2);
		boot(0, 1, 0, 1, 1);
		chk("rslow", 16'h0, 16'(slow));
		$display("test done: wait");
		close_out();
	end
endmodule : boot_and_low_power_control_tb
`default_nettype wire

// ### testbench/host_uart_model.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host side of the loader link: one 8N1 frame for each go pulse
module host_uart_model #(
	parameter int BITC = 16
) (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [7:0] i_byte,
	output logic o_busy,
	output logic o_rx
);
	logic [9:0] frame; // Stop, data LSB first, start
	int n;
	initial
	begin
		o_rx = 1'b1;
		o_busy = 1'b0;
	end
	// Line idles high between frames, matching the pull-up
	always
	begin
		@(posedge i_clk iff i_go);
		o_busy = 1'b1;
		frame = {1'b1, i_byte, 1'b0};
		for (n = 0; n < 10; n++)
		begin
			#1 o_rx = frame[n];
			repeat (BITC) @(posedge i_clk);
		end
		o_busy = 1'b0;
	end
endmodule : host_uart_model
`default_nettype wire
